// [design/pcr_pkg.sv]
// constants and types for the secondary bus clock-stop controller
package pcr_pkg;
   // ------------------------------------------------------------
   // configuration space
   // ------------------------------------------------------------
   localparam int CFG_AW = 8;
   localparam int CFG_DW = 8;
   localparam logic [CFG_AW-1:0] OFS_BRIDGE_CTRL = 8'h3e;
   localparam logic [CFG_AW-1:0] OFS_CLK_STATUS = 8'hda;
   localparam int BIT_SEC_RST_CTL = 6;
   localparam int BIT_CLK_RUN = 0;
   localparam logic SEC_RST_CTL_RST = 1'b0;
   localparam logic STRAP_RST = 1'b0;
   // ------------------------------------------------------------
   // timing counts, in clk_i cycles
   // ------------------------------------------------------------
   localparam int MIN_RUN_CYC = 512;
   localparam int REL_WAIT_CYC = 8;
   localparam int SYNC_LAT_CYC = 3;
   localparam int CNT_W = 10;
   // ------------------------------------------------------------
   // interrupt lines
   // ------------------------------------------------------------
   localparam int INTX_N = 4;
   localparam int INTX_IW = 2;
   // ------------------------------------------------------------
   // clock-stop states, gray along run-release-stop-restart
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_REL = 2'h1,
      ST_STOP = 2'h3,
      ST_RESTART = 2'h2
   } pcr_state_e;
endpackage : pcr_pkg

// [design/pcr_intx_if.sv]
// interrupt line levels and upstream message requests
`timescale 1ns/1ns
`default_nettype none
interface pcr_intx_if;
   logic [pcr_pkg::INTX_N-1:0] lines;
   logic msg_valid;
   logic msg_assert;
   logic [pcr_pkg::INTX_IW-1:0] msg_line;
   modport tracker (input lines, output msg_valid, output msg_assert, output msg_line);
   modport ctrl (output lines, input msg_valid, input msg_assert, input msg_line);
endinterface : pcr_intx_if
`default_nettype wire

// [design/pcr_intx_track.sv]
// interrupt line change tracker, one upstream message per change
`timescale 1ns/1ns
`default_nettype none
module pcr_intx_track (
   input wire logic clk_i,
   input wire logic rstn_i,
   pcr_intx_if.tracker trk
);
   import pcr_pkg::*;

   logic [INTX_N-1:0] seen_q;
   logic [INTX_N-1:0] diff;
   logic [INTX_IW-1:0] pick;
   logic valid_q;
   logic assert_q;
   logic [INTX_IW-1:0] line_q;

   // lowest changed line wins; others wait their turn
   function automatic logic [INTX_IW-1:0] first_set(input logic [INTX_N-1:0] v);
      logic [INTX_IW-1:0] r;
      r = '0;
      for (int i = INTX_N - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = INTX_IW'(i);
         end
      end
      return r;
   endfunction : first_set

   assign diff = trk.lines ^ seen_q;
   assign pick = first_set(diff);

   // ------------------------------------------------------------
   // change detection, runs whether or not bus clocks are stopped
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         seen_q <= '0;
         valid_q <= 1'b0;
         assert_q <= 1'b0;
         line_q <= '0;
      end else begin
         valid_q <= |diff;
         if (|diff) begin
            seen_q[pick] <= trk.lines[pick];
            assert_q <= trk.lines[pick];
            line_q <= pick;
         end
      end
   end

   assign trk.msg_valid = valid_q;
   assign trk.msg_assert = assert_q;
   assign trk.msg_line = line_q;

   intx_report_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
      (|diff) |=> valid_q)
      else $error("interrupt line change produced no message");
   intx_level_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
      valid_q |-> assert_q == seen_q[line_q])
      else $error("message level differs from tracked line");
endmodule : pcr_intx_track
`default_nettype wire

// [design/pcr_clock_run_top.sv]
// clock-stop central resource master for the secondary pci bus
`timescale 1ns/1ns
`default_nettype none
module pcr_clock_run_top #(
   parameter int MIN_RUN = pcr_pkg::MIN_RUN_CYC,
   parameter int REL_WAIT = pcr_pkg::REL_WAIT_CYC
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic clock_stop_protocol_strap_i,
   input wire logic shared_io_pin_zero_i,
   output logic shared_io_pin_zero_o,
   output logic shared_io_pin_zero_oe_o,
   input wire logic gpio_out_i,
   input wire logic gpio_oe_i,
   output logic gpio_in_o,
   input wire logic serialized_irq_pending_i,
   input wire logic ds_txn_req_i,
   output logic ds_txn_go_o,
   input wire logic [pcr_pkg::INTX_N-1:0] intx_n_i,
   output logic intx_msg_valid_o,
   output logic intx_msg_assert_o,
   output logic [pcr_pkg::INTX_IW-1:0] intx_msg_line_o,
   input wire logic [pcr_pkg::CFG_AW-1:0] cfg_addr_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [pcr_pkg::CFG_DW-1:0] cfg_wdata_i,
   output logic [pcr_pkg::CFG_DW-1:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   output logic secondary_bus_reset_out_n_o,
   output logic secondary_clock_running_flag_o
);
   import pcr_pkg::*;

   localparam logic [CNT_W-1:0] MIN_LAST = CNT_W'(MIN_RUN - 1);
   localparam logic [CNT_W-1:0] REL_LAST = CNT_W'(REL_WAIT - 1);
   localparam logic [CNT_W-1:0] SYNC_LAT = CNT_W'(SYNC_LAT_CYC);

   pcr_state_e state_q, state_d;
   logic strap_s1_q, strap_q;
   logic pin_s1_q, pin_q;
   logic [INTX_N-1:0] intx_s1_q, intx_s2_q;
   logic sec_rst_ctl_q;
   logic ctl_rst;
   logic [CNT_W-1:0] min_cnt_q;
   logic [CNT_W-1:0] rel_cnt_q;
   logic stop_ok, dev_hold, wake;
   logic clk_run_q;
   logic pin_o_q, pin_oe_q;
   logic ds_go_q;
   logic [CFG_DW-1:0] rdata_q;
   logic rvalid_q;
   logic bus_rst_n_q;
   logic msg_valid_q, msg_assert_q;
   logic [INTX_IW-1:0] msg_line_q;

   pcr_intx_if intx_bus ();

   // ------------------------------------------------------------
   // input synchronisers: strap, pin and interrupt lines
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         strap_s1_q <= STRAP_RST;
         strap_q <= STRAP_RST;
         pin_s1_q <= 1'b1;
         pin_q <= 1'b1;
         intx_s1_q <= '1;
         intx_s2_q <= '1;
      end else begin
         strap_s1_q <= clock_stop_protocol_strap_i;
         strap_q <= strap_s1_q;
         pin_s1_q <= shared_io_pin_zero_i;
         pin_q <= pin_s1_q;
         intx_s1_q <= intx_n_i;
         intx_s2_q <= intx_s1_q;
      end
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         sec_rst_ctl_q <= SEC_RST_CTL_RST;
         rdata_q <= '0;
         rvalid_q <= 1'b0;
      end else begin
         if (cfg_wr_i && cfg_addr_i == OFS_BRIDGE_CTRL) begin
            sec_rst_ctl_q <= cfg_wdata_i[BIT_SEC_RST_CTL];
         end
         rvalid_q <= cfg_rd_i;
         rdata_q <= '0;
         if (cfg_rd_i && cfg_addr_i == OFS_CLK_STATUS) begin
            rdata_q[BIT_CLK_RUN] <= clk_run_q;
         end else if (cfg_rd_i && cfg_addr_i == OFS_BRIDGE_CTRL) begin
            rdata_q[BIT_SEC_RST_CTL] <= sec_rst_ctl_q;
         end
      end
   end

   // bus reset pin asserted under global reset and while the bit is set
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         bus_rst_n_q <= 1'b0;
      end else begin
         bus_rst_n_q <= !sec_rst_ctl_q;
      end
   end

   assign ctl_rst = !rstn_i || sec_rst_ctl_q;

   // ------------------------------------------------------------
   // stop and wake decisions
   // ------------------------------------------------------------
   // our own earlier drive echoes through the synchroniser, so the
   // release window ignores the pin for its first few cycles
   assign dev_hold = (rel_cnt_q >= SYNC_LAT) && !pin_q;
   assign stop_ok = strap_q && !ds_txn_req_i && !serialized_irq_pending_i
                    && min_cnt_q == '0 && !ctl_rst;
   assign wake = ds_txn_req_i || serialized_irq_pending_i || !pin_q;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (stop_ok) state_d = ST_REL;
         end
         ST_REL: begin
            if (!stop_ok || dev_hold) begin
               state_d = ST_RUN;
            end else if (rel_cnt_q == REL_LAST) begin
               state_d = ST_STOP;
            end
         end
         ST_STOP: begin
            if (wake) state_d = ST_RESTART;
         end
         ST_RESTART: begin
            state_d = ST_RUN;
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
      if (ctl_rst || !strap_q) begin
         state_d = ST_RUN;
      end
   end

   // ------------------------------------------------------------
   // state, clock enable and counters
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (ctl_rst) begin
         state_q <= ST_RUN;
         clk_run_q <= 1'b1;
      end else begin
         state_q <= state_d;
         clk_run_q <= state_d != ST_STOP;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ctl_rst) begin
         min_cnt_q <= MIN_LAST;
      end else if (state_q == ST_RESTART || (state_q == ST_REL && dev_hold)) begin
         min_cnt_q <= MIN_LAST;
      end else if (state_q == ST_RUN && min_cnt_q != '0) begin
         min_cnt_q <= min_cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ctl_rst || state_q != ST_REL) begin
         rel_cnt_q <= '0;
      end else if (rel_cnt_q != REL_LAST) begin
         rel_cnt_q <= rel_cnt_q + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // pin zero: clock-run open drain or plain general-purpose pin
   // ------------------------------------------------------------
   // drives only low in clock-run mode; watches the pin for another master during release and stop
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         pin_o_q <= 1'b0;
         pin_oe_q <= 1'b0;
         ds_go_q <= 1'b0;
      end else if (strap_q) begin
         pin_o_q <= 1'b0;
         pin_oe_q <= state_d == ST_RUN || state_d == ST_RESTART;
         ds_go_q <= state_d == ST_RUN && ds_txn_req_i;
      end else begin
         pin_o_q <= gpio_out_i;
         pin_oe_q <= gpio_oe_i;
         ds_go_q <= ds_txn_req_i;
      end
   end

   // ------------------------------------------------------------
   // interrupt message tracking
   // ------------------------------------------------------------
   assign intx_bus.lines = ~intx_s2_q;

   pcr_intx_track u_intx (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .trk(intx_bus.tracker)
   );

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         msg_valid_q <= 1'b0;
         msg_assert_q <= 1'b0;
         msg_line_q <= '0;
      end else begin
         msg_valid_q <= intx_bus.msg_valid;
         msg_assert_q <= intx_bus.msg_assert;
         msg_line_q <= intx_bus.msg_line;
      end
   end

   assign shared_io_pin_zero_o = pin_o_q;
   assign shared_io_pin_zero_oe_o = pin_oe_q;
   assign gpio_in_o = pin_q;
   assign ds_txn_go_o = ds_go_q;
   assign intx_msg_valid_o = msg_valid_q;
   assign intx_msg_assert_o = msg_assert_q;
   assign intx_msg_line_o = msg_line_q;
   assign cfg_rdata_o = rdata_q;
   assign cfg_rvalid_o = rvalid_q;
   assign secondary_bus_reset_out_n_o = bus_rst_n_q;
   assign secondary_clock_running_flag_o = clk_run_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_wake;
      state_q == ST_RESTART && pin_oe_q ##1 state_q == ST_RUN && clk_run_q;
   endsequence

   strap_off_run_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
      !strap_q |=> clk_run_q)
      else $error("clocks stopped with protocol disabled");
   pin_drive_low_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
      strap_q && $past(strap_q) |-> !shared_io_pin_zero_o)
      else $error("clock-run line driven high");
   status_read_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
      cfg_rd_i && cfg_addr_i == OFS_CLK_STATUS |=> cfg_rvalid_o
      && cfg_rdata_o[BIT_CLK_RUN] == $past(clk_run_q))
      else $error("status read disagrees with clock state");
   stop_release_a : assert property (@(posedge clk_i) disable iff (ctl_rst)
      state_q == ST_STOP |-> !pin_oe_q)
      else $error("line driven while clocks stopped");
   min_run_a : assert property (@(posedge clk_i) disable iff (ctl_rst)
      state_q == ST_RUN && min_cnt_q != '0 |=> state_q == ST_RUN)
      else $error("left run before minimum interval");
   min_load_a : assert property (@(posedge clk_i) disable iff (ctl_rst)
      state_q == ST_RESTART |=> min_cnt_q == MIN_LAST)
      else $error("minimum run count not loaded");
   irq_hold_a : assert property (@(posedge clk_i) disable iff (ctl_rst)
      serialized_irq_pending_i && clk_run_q |=> clk_run_q)
      else $error("clocks stopped with irq pending");
   ds_restart_a : assert property (@(posedge clk_i) disable iff (ctl_rst)
      state_q == ST_STOP && ds_txn_req_i && strap_q |=> s_wake)
      else $error("transaction did not restart clocks");
   reset_run_a : assert property (@(posedge clk_i)
      sec_rst_ctl_q |=> clk_run_q && state_q == ST_RUN)
      else $error("clocks not running in bus reset");
   bus_rst_follow_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
      sec_rst_ctl_q |=> !secondary_bus_reset_out_n_o)
      else $error("bus reset not asserted");
   stop_guard_a : assert property (@(posedge clk_i) disable iff (ctl_rst)
      state_q == ST_RUN ##1 state_q == ST_REL |-> $past(stop_ok))
      else $error("stop requested while work outstanding");
endmodule : pcr_clock_run_top
`default_nettype wire

// [verif/pcr_dev_model.sv]
// bus device model sharing the open-drain clock-run line
`timescale 1ns/1ns
`default_nettype none
module pcr_dev_model (
   input wire logic clk_i,
   input wire logic need_irq_i,
   input wire logic clocks_on_i,
   output logic pull_o
);
   // ------------------------------------------------------------
   // restart request
   // ------------------------------------------------------------
   initial pull_o = 1'b0;
   // pulls low only while clocks are off; the line relies on a pull-up otherwise
   always @(posedge clk_i) begin
      pull_o <= need_irq_i && !clocks_on_i;
   end
endmodule : pcr_dev_model
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the clock-stop controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import pcr_pkg::*;
   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   localparam int MINR = 16;
   localparam int RELW = 6;
   localparam int LONG = MINR + RELW + 30;
   logic clk = 1'b0, rstn = 1'b0, strap = 1'b0, gout = 1'b0, goe = 1'b0;
   logic irq = 1'b0, ds = 1'b0, wr = 1'b0, rd = 1'b0, need = 1'b0;
   logic [3:0] intx = 4'hf;
   logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
   logic pull, pin_o, pin_oe, gin, go, mv, ma, rv, bro_n, run;
   logic [1:0] ml;
   wire pin_w;
   int fail_count = 0, cmp_count = 0, n, k, m, oe_cnt = 0;
   int exp_q[$];
   // open-drain line with pull-up; gpio mode drives both levels
   assign pin_w = pull ? 1'b0 : (pin_oe ? pin_o : 1'b1);
   always #25 clk = ~clk;
   pcr_clock_run_top #(.MIN_RUN(MINR), .REL_WAIT(RELW)) dut (
      .clk_i(clk), .rstn_i(rstn), .clock_stop_protocol_strap_i(strap),
      .shared_io_pin_zero_i(pin_w), .shared_io_pin_zero_o(pin_o),
      .shared_io_pin_zero_oe_o(pin_oe), .gpio_out_i(gout), .gpio_oe_i(goe), .gpio_in_o(gin),
      .serialized_irq_pending_i(irq), .ds_txn_req_i(ds), .ds_txn_go_o(go), .intx_n_i(intx),
      .intx_msg_valid_o(mv), .intx_msg_assert_o(ma), .intx_msg_line_o(ml),
      .cfg_addr_i(addr), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_wdata_i(wd), .cfg_rdata_o(rdata),
      .cfg_rvalid_o(rv), .secondary_bus_reset_out_n_o(bro_n),
      .secondary_clock_running_flag_o(run));
   pcr_dev_model dev (.clk_i(clk), .need_irq_i(need), .clocks_on_i(run), .pull_o(pull));
   // ------------------------------------------------------------
   // checking helpers
   // ------------------------------------------------------------
   task automatic err(input string s);
      fail_count++;
      $display("Error at %0t: %s", $time, s);
   endtask : err
   task chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) err($sformatf("got %h expected %h", got, exp));
   endtask : chk
   task chkb(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask : chkb
   task endt(input string s);
      $display("test %s done", s);
   endtask : endt
   // message model: queue of line*2+assert in expected order
   // sampled at the falling edge, where registered outputs have settled
   always @(negedge clk) begin
      if (pin_oe === 1'b1 && pin_o === 1'b0) oe_cnt++;
      if (mv === 1'b1) begin
         cmp_count++;
         if (exp_q.size() == 0) err("unexpected interrupt message");
         else if ({ml, ma} !== 3'(exp_q.pop_front())) err("wrong interrupt message");
      end
   end
   task wflag(input logic v, input int lim);
      n = 0;
      while (run !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
      chkb(run, v);
   endtask : wflag
   task hold(input logic v, input int lim);
      repeat (lim) begin
         @(negedge clk);
         chkb(run, v);
      end
   endtask : hold
   task cfg(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
      @(negedge clk);
      wr = w;
      rd = !w;
      addr = a;
      wd = d;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b0;
      if (!w) begin
         chkb(rv, 1'b1);
         chk(rdata, e);
      end
   endtask : cfg
   task summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   // ------------------------------------------------------------
   // watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      #(5000 * 50);
      err("watchdog expired");
      summarize();
   end
   initial begin
      void'($urandom(57862));
      repeat (3) @(negedge clk);
      chkb(bro_n, 1'b0);
      chkb(run, 1'b1);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      chkb(bro_n, 1'b1);
      endt("reset");
      gout = 1'($urandom);
      goe = 1'b1;
      ds = 1'b1;
      repeat (5) @(negedge clk);
      chkb(pin_oe, 1'b1);
      chkb(pin_o, gout);
      chkb(gin, gout);
      chkb(go, 1'b1);
      goe = 1'b0;
      ds = 1'b0;
      hold(1'b1, LONG);
      chkb(gin, 1'b1);
      endt("gpio");
      strap = 1'b1;
      wflag(1'b0, LONG);
      cfg(1'b0, OFS_CLK_STATUS, 8'h00, 8'h00);
      cfg(1'b1, OFS_CLK_STATUS, 8'hff, 8'h00);
      cfg(1'b0, OFS_CLK_STATUS, 8'h00, 8'h00);
      cfg(1'b0, 8'h55, 8'h00, 8'h00);
      hold(1'b0, 10);
      endt("stop");
      k = $urandom_range(3);
      exp_q.push_back(k * 2 + 1);
      intx[k] = 1'b0;
      repeat (8) @(negedge clk);
      exp_q.push_back(k * 2);
      intx[k] = 1'b1;
      repeat (8) @(negedge clk);
      for (int i = 0; i < 4; i++) exp_q.push_back(i * 2 + 1);
      intx = 4'h0;
      repeat (12) @(negedge clk);
      for (int i = 0; i < 4; i++) exp_q.push_back(i * 2);
      intx = 4'hf;
      repeat (12) @(negedge clk);
      chk(8'(exp_q.size()), 8'h00);
      chkb(run, 1'b0);
      endt("intx");
      m = oe_cnt;
      ds = 1'b1;
      wflag(1'b1, 4);
      chkb(go, 1'b0);
      repeat (4) @(negedge clk);
      chkb(go, 1'b1);
      chkb(1'(oe_cnt > m), 1'b1);
      ds = 1'b0;
      wflag(1'b0, LONG);
      chkb(1'(n >= MINR), 1'b1);
      endt("downstream");
      need = 1'b1;
      wflag(1'b1, 8);
      need = 1'b0;
      wflag(1'b0, LONG);
      chkb(1'(n >= MINR), 1'b1);
      endt("device wake");
      need = 1'b1;
      wflag(1'b1, 8);
      irq = 1'b1;
      need = 1'b0;
      hold(1'b1, LONG);
      irq = 1'b0;
      wflag(1'b0, LONG);
      endt("serial irq");
      cfg(1'b1, OFS_BRIDGE_CTRL, 8'h40, 8'h00);
      repeat (2) @(negedge clk);
      chkb(bro_n, 1'b0);
      chkb(run, 1'b1);
      cfg(1'b0, OFS_BRIDGE_CTRL, 8'h00, 8'h40);
      cfg(1'b0, OFS_CLK_STATUS, 8'h00, 8'h01);
      hold(1'b1, LONG);
      cfg(1'b1, OFS_BRIDGE_CTRL, 8'h00, 8'h00);
      repeat (2) @(negedge clk);
      chkb(bro_n, 1'b1);
      wflag(1'b0, LONG);
      endt("bus reset");
      strap = 1'b0;
      wflag(1'b1, 8);
      chkb(pin_oe, goe);
      endt("strap off");
      summarize();
   end
endmodule : tb_top
`default_nettype wire
